// ### include/tlia_pkg.sv
// Package for the two-level interrupt arbiter: source order, vectors, register layouts
`default_nettype none

package tlia_pkg;

  // ********************************************************************
  // Source indices in polling order, first to last
  // ********************************************************************
  localparam int TLIA_NSRC     = 11;
  localparam int SRC_SUPPLY    = 0;   // Supply monitor
  localparam int SRC_WATCHDOG  = 1;   // Watchdog timeout
  localparam int SRC_EXT0      = 2;   // External 0
  localparam int SRC_ADC       = 3;   // Converter ready
  localparam int SRC_TIMER0    = 4;   // Timer 0
  localparam int SRC_EXT1      = 5;   // External 1
  localparam int SRC_TIMER1    = 6;   // Timer 1
  localparam int SRC_SERIF     = 7;   // Two-wire / SPI
  localparam int SRC_UART      = 8;   // Serial port
  localparam int SRC_TIMER2    = 9;   // Timer 2
  localparam int SRC_INTERVAL  = 10;  // Interval counter

  // ********************************************************************
  // Enable and priority register layouts
  // ********************************************************************
  localparam int GLOBAL_EN_BIT = 7;   // Global enable in the enable byte
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'h00;
  localparam logic [7:0] EXTRA_RESET    = 8'h00;
  // Enable byte bits 0..6: ext0, timer0, ext1, timer1, uart, timer2, adc
  // Extra byte bits 0..2 enable serif, supply, interval; bits 4..6 their priorities

  // ********************************************************************
  // Vector addresses
  // ********************************************************************
  localparam logic [15:0] VEC_EXT0     = 16'h0003;
  localparam logic [15:0] VEC_TIMER0   = 16'h000B;
  localparam logic [15:0] VEC_EXT1     = 16'h0013;
  localparam logic [15:0] VEC_TIMER1   = 16'h001B;
  localparam logic [15:0] VEC_UART     = 16'h0023;
  localparam logic [15:0] VEC_TIMER2   = 16'h002B;
  localparam logic [15:0] VEC_ADC      = 16'h0033;
  localparam logic [15:0] VEC_SERIF    = 16'h003B;
  localparam logic [15:0] VEC_SUPPLY   = 16'h0043;
  localparam logic [15:0] VEC_INTERVAL = 16'h0053;
  localparam logic [15:0] VEC_WATCHDOG = 16'h005B;

  // Raw peripheral flags that feed the arbiter
  typedef struct packed {
    logic supply_monitor_flag;
    logic watchdog_timeout_flag;
    logic external0_request_flag;
    logic [1:0] converter_ready_flags;
    logic timer0_overflow;
    logic external1_request_flag;
    logic timer1_overflow;
    logic two_wire_flag;
    logic spi_flag;
    logic uart_receive_done;
    logic uart_transmit_done;
    logic timer2_overflow;
    logic timer2_external_flag;
    logic interval_counter_flag;
  } tlia_flags_type;

  // Request issued to the core
  typedef struct packed {
    logic        valid;      // Request outstanding
    logic        high;       // Level granted
    logic [3:0]  source;     // Winning source index
    logic [15:0] vector;     // Vector address
  } tlia_req_type;

endpackage : tlia_pkg

`default_nettype wire

// ### hw/tlia_picker.sv
// Fixed-order first-one picker for one priority level
`timescale 1ns/1ps
`default_nettype none

module tlia_picker #(
  parameter int N = 11
) (
  // Candidate requests, bit 0 polled first
  input  wire logic [N-1:0] cand,
  // Result
  output logic              found,
  output logic [3:0]        index
);

  // Index is four bits wide, so more than sixteen candidates cannot be served
  if (N < 1 || N > 16) begin : g_bad_n
    $error("tlia_picker: N out of range");
  end

  // ********************************************************************
  // Priority scan, lowest index wins
  // ********************************************************************
  always_comb begin
    found = 1'b0;
    index = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (cand[i]) begin
        found = 1'b1;
        index = 4'(i);
      end
    end
  end

endmodule : tlia_picker

`default_nettype wire

// ### hw/tlia_arbiter.sv
// Two-level interrupt arbiter: masking, priority levels, polling order, nesting, vectors
`timescale 1ns/1ps
`default_nettype none

module tlia_arbiter
  import tlia_pkg::*;
#(
  parameter int TIMEOUT_W = 4
) (
  // Clock and reset
  input  wire logic                 CLK_SYS,
  input  wire logic                 RST_N,
  // Peripheral flags, same clock domain
  input  wire tlia_pkg::tlia_flags_type FLAGS,
  // Configuration bits written by software
  input  wire logic [7:0]           ENABLE_WR_DATA,
  input  wire logic                 ENABLE_WR,
  input  wire logic [7:0]           PRIORITY_WR_DATA,
  input  wire logic                 PRIORITY_WR,
  input  wire logic [7:0]           EXTRA_WR_DATA,
  input  wire logic                 EXTRA_WR,
  input  wire logic                 WATCHDOG_IRQ_SELECT,
  input  wire logic [TIMEOUT_W-1:0] WATCHDOG_TIMEOUT,
  // Core handshake
  input  wire logic                 CORE_ACCEPT,
  input  wire logic                 CORE_RETURN,
  // Request to the core
  output tlia_pkg::tlia_req_type    REQ,
  output logic                      PUSH_PC,
  output logic                      LOAD_PC,
  output logic [15:0]               LOAD_VECTOR,
  // Status
  output logic [7:0]                ENABLE_REG,
  output logic [7:0]                PRIORITY_REG,
  output logic [7:0]                EXTRA_REG,
  output logic [1:0]                IN_SERVICE
);

  // Refuse timeout widths the zero compare is not meant to serve
  if (TIMEOUT_W < 1 || TIMEOUT_W > 16) begin : g_bad_timeout_w
    $error("tlia_arbiter: TIMEOUT_W out of range");
  end

  // ********************************************************************
  // Sequencer states, gray along idle -> push -> load
  // ********************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PUSH = 2'b01,
    ST_LOAD = 2'b11
  } tlia_state_type;

  tlia_state_type state;                // Entry sequence state
  tlia_state_type next_state;
  logic [7:0]     enable_r;             // Enable byte
  logic [7:0]     priority_r;           // Priority byte
  logic [7:0]     extra_r;              // Secondary enable and priority
  logic [1:0]     in_service;           // Bit 1 high level, bit 0 low level
  logic [1:0]     next_in_service;
  logic [15:0]    vector_r;             // Latched vector of the taken request
  logic           level_r;              // Latched level of the taken request

  // ********************************************************************
  // Source requests
  // ********************************************************************
  wire logic [TLIA_NSRC-1:0] raw;       // One request per source
  wire logic [TLIA_NSRC-1:0] en;        // Individual enables
  wire logic [TLIA_NSRC-1:0] hi;        // Priority bits
  wire logic                 wd_armed;  // Watchdog may interrupt
  wire logic                 gie;       // Global enable

  assign wd_armed = WATCHDOG_IRQ_SELECT && (WATCHDOG_TIMEOUT != '0);
  assign gie      = enable_r[GLOBAL_EN_BIT];

  // Combined flags share one request line
  assign raw[SRC_SUPPLY]   = FLAGS.supply_monitor_flag;
  assign raw[SRC_WATCHDOG] = FLAGS.watchdog_timeout_flag && wd_armed;
  assign raw[SRC_EXT0]     = FLAGS.external0_request_flag;
  assign raw[SRC_ADC]      = |FLAGS.converter_ready_flags;
  assign raw[SRC_TIMER0]   = FLAGS.timer0_overflow;
  assign raw[SRC_EXT1]     = FLAGS.external1_request_flag;
  assign raw[SRC_TIMER1]   = FLAGS.timer1_overflow;
  assign raw[SRC_SERIF]    = FLAGS.two_wire_flag | FLAGS.spi_flag;
  assign raw[SRC_UART]     = FLAGS.uart_receive_done | FLAGS.uart_transmit_done;
  assign raw[SRC_TIMER2]   = FLAGS.timer2_overflow | FLAGS.timer2_external_flag;
  assign raw[SRC_INTERVAL] = FLAGS.interval_counter_flag;

  // Enables: global gates all but the watchdog
  assign en[SRC_SUPPLY]    = gie && extra_r[1];
  assign en[SRC_WATCHDOG]  = 1'b1;
  assign en[SRC_EXT0]      = gie && enable_r[0];
  assign en[SRC_ADC]       = gie && enable_r[6];
  assign en[SRC_TIMER0]    = gie && enable_r[1];
  assign en[SRC_EXT1]      = gie && enable_r[2];
  assign en[SRC_TIMER1]    = gie && enable_r[3];
  assign en[SRC_SERIF]     = gie && extra_r[0];
  assign en[SRC_UART]      = gie && enable_r[4];
  assign en[SRC_TIMER2]    = gie && enable_r[5];
  assign en[SRC_INTERVAL]  = gie && extra_r[2];

  // Priority: 1 selects high, watchdog is forced high
  assign hi[SRC_SUPPLY]    = extra_r[5];
  assign hi[SRC_WATCHDOG]  = 1'b1;
  assign hi[SRC_EXT0]      = priority_r[0];
  assign hi[SRC_ADC]       = priority_r[6];
  assign hi[SRC_TIMER0]    = priority_r[1];
  assign hi[SRC_EXT1]      = priority_r[2];
  assign hi[SRC_TIMER1]    = priority_r[3];
  assign hi[SRC_SERIF]     = extra_r[4];
  assign hi[SRC_UART]      = priority_r[4];
  assign hi[SRC_TIMER2]    = priority_r[5];
  assign hi[SRC_INTERVAL]  = extra_r[6];

  // ********************************************************************
  // Arbitration per level
  // ********************************************************************
  wire logic [TLIA_NSRC-1:0] cand_hi = raw & en & hi;
  wire logic [TLIA_NSRC-1:0] cand_lo = raw & en & ~hi;
  wire logic                 found_hi;
  wire logic                 found_lo;
  wire logic [3:0]           idx_hi;
  wire logic [3:0]           idx_lo;

  // Fixed polling order, lowest index first
  tlia_picker #(.N(TLIA_NSRC)) u_pick_hi (.cand(cand_hi), .found(found_hi), .index(idx_hi));
  tlia_picker #(.N(TLIA_NSRC)) u_pick_lo (.cand(cand_lo), .found(found_lo), .index(idx_lo));

  // High may run unless a high routine is active; low only when idle
  wire logic grant_hi = found_hi && !in_service[1];
  wire logic grant_lo = found_lo && (in_service == 2'b00);
  wire logic win_hi   = grant_hi;
  wire logic any_win  = (grant_hi || grant_lo) && (state == ST_IDLE);
  wire logic [3:0] win_idx = win_hi ? idx_hi : idx_lo;

  // Vector table lookup
  function automatic logic [15:0] vec_of(input logic [3:0] s);
    unique case (s)
      4'(SRC_SUPPLY):   vec_of = VEC_SUPPLY;
      4'(SRC_WATCHDOG): vec_of = VEC_WATCHDOG;
      4'(SRC_EXT0):     vec_of = VEC_EXT0;
      4'(SRC_ADC):      vec_of = VEC_ADC;
      4'(SRC_TIMER0):   vec_of = VEC_TIMER0;
      4'(SRC_EXT1):     vec_of = VEC_EXT1;
      4'(SRC_TIMER1):   vec_of = VEC_TIMER1;
      4'(SRC_SERIF):    vec_of = VEC_SERIF;
      4'(SRC_UART):     vec_of = VEC_UART;
      4'(SRC_TIMER2):   vec_of = VEC_TIMER2;
      4'(SRC_INTERVAL): vec_of = VEC_INTERVAL;
      default:          vec_of = 16'h0000;      // Unused indices
    endcase
  endfunction : vec_of

  wire logic [15:0] win_vec = vec_of(win_idx);

  // ********************************************************************
  // Entry sequencer: request, push, load
  // ********************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (any_win && CORE_ACCEPT) next_state = ST_PUSH;
      ST_PUSH: next_state = ST_LOAD;
      ST_LOAD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;      // Illegal code recovers
    endcase
  end

  // In-service: set on accept, clear highest active on return
  always_comb begin
    next_in_service = in_service;
    if (CORE_RETURN) begin
      if (in_service[1]) next_in_service[1] = 1'b0;
      else next_in_service[0] = 1'b0;
    end
    if (state == ST_IDLE && any_win && CORE_ACCEPT) begin
      next_in_service[win_hi ? 1 : 0] = 1'b1;
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  // Software-written configuration, zero after reset
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      enable_r   <= ENABLE_RESET;
      priority_r <= PRIORITY_RESET;
      extra_r    <= EXTRA_RESET;
    end else begin
      if (ENABLE_WR) enable_r <= ENABLE_WR_DATA;
      if (PRIORITY_WR) priority_r <= PRIORITY_WR_DATA & 8'h7F;
      if (EXTRA_WR) extra_r <= EXTRA_WR_DATA & 8'h77;
    end
  end

  // Sequencer and latched vector
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      state      <= ST_IDLE;
      in_service <= 2'b00;
      vector_r   <= 16'h0000;
      level_r    <= 1'b0;
    end else begin
      state      <= next_state;
      in_service <= next_in_service;
      if (state == ST_IDLE && any_win && CORE_ACCEPT) begin
        vector_r <= win_vec;
        level_r  <= win_hi;
      end
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign REQ.valid    = any_win;
  assign REQ.high     = win_hi;
  assign REQ.source   = any_win ? win_idx : 4'h0;
  assign REQ.vector   = any_win ? win_vec : 16'h0000;
  assign PUSH_PC      = (state == ST_PUSH);
  assign LOAD_PC      = (state == ST_LOAD);
  assign LOAD_VECTOR  = vector_r;
  assign ENABLE_REG   = enable_r;
  assign PRIORITY_REG = priority_r;
  assign EXTRA_REG    = extra_r;
  assign IN_SERVICE   = in_service;

  // ********************************************************************
  // Checks
  // ********************************************************************
  sequence s_entry;
    PUSH_PC ##1 LOAD_PC;
  endsequence

  AST_PUSH_THEN_LOAD: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && CORE_ACCEPT) |=> s_entry) else $error("push/load order broken");
  AST_HIGH_FIRST: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (found_hi && !in_service[1] && REQ.valid) |-> REQ.high) else $error("low granted over high");
  AST_SAME_LEVEL_BLOCK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.high) |-> !in_service[1]) else $error("same level preempted");
  AST_LOW_WAITS: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && !REQ.high) |-> (in_service == 2'b00)) else $error("low nested");
  AST_WD_GATED: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.source == 4'(SRC_WATCHDOG)) |-> (wd_armed && REQ.high)) else $error("watchdog misgated");
  AST_GIE_MASK: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && !gie) |-> (REQ.source == 4'(SRC_WATCHDOG))) else $error("global mask ignored");
  AST_WD_VEC: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (REQ.valid && REQ.source == 4'(SRC_WATCHDOG) && CORE_ACCEPT) |-> ##2 (LOAD_VECTOR == VEC_WATCHDOG))
    else $error("watchdog vector wrong");
  AST_RETURN_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (CORE_RETURN && in_service == 2'b11 && !(REQ.valid && CORE_ACCEPT)) |=> (in_service == 2'b01))
    else $error("return did not clear level");
  AST_NEST: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    (in_service == 2'b01 && found_hi && state == ST_IDLE) |-> REQ.valid) else $error("high did not preempt");

endmodule : tlia_arbiter

`default_nettype wire

// ### sim/tlia_core_model.sv
// Behavioural model of the core that takes requests from the interrupt arbiter
`timescale 1ns/1ps
`default_nettype none

module tlia_core_model
  import tlia_pkg::*;
(
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Arbiter side
  input  wire tlia_pkg::tlia_req_type req,
  input  wire logic                   push_pc,
  input  wire logic                   load_pc,
  output logic                        core_accept,
  output logic                        core_return,
  // Bench side
  input  wire logic                   accept_en,
  input  wire logic                   ret_cmd,
  output logic                        order_bad,
  output logic [7:0]                  takes
);
  logic pushed;  // Push seen on the previous edge

  // Accept only while a request stands; the bench decides when the core is willing
  assign core_accept = accept_en & req.valid;
  // Return from the service routine, one cycle per command
  assign core_return = ret_cmd;

  // ********************************************************************
  // Push must come just before the vector load
  // ********************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pushed    <= 1'b0;
      order_bad <= 1'b0;
      takes     <= 8'h00;
    end else begin
      pushed <= push_pc;
      if (load_pc && !pushed) begin
        order_bad <= 1'b1;
      end
      if (load_pc) begin
        takes <= takes + 8'h01;
      end
    end
  end
endmodule : tlia_core_model

`default_nettype wire

// ### sim/tb_two_level_interrupt_arbiter.sv
// Self-checking bench for the two-level interrupt arbiter
`timescale 1ns/1ps
`default_nettype none

module tb_two_level_interrupt_arbiter;
  import tlia_pkg::*;

  // One table row: flags and settings beside the grant they should give
  typedef struct packed {
    logic [14:0] flags;
    logic [7:0]  en;
    logic [7:0]  pri;
    logic [7:0]  ext;
    logic [3:0]  src;
    logic [15:0] vec;
    logic        high;
  } tlia_row_type;

  logic           CLK_SYS = 1'b0;
  logic           RST_N = 1'b0;
  tlia_flags_type FLAGS = '0;
  logic [7:0]     ENABLE_WR_DATA = 8'h00, PRIORITY_WR_DATA = 8'h00, EXTRA_WR_DATA = 8'h00;
  logic           ENABLE_WR = 1'b0, PRIORITY_WR = 1'b0, EXTRA_WR = 1'b0;
  logic           WATCHDOG_IRQ_SELECT = 1'b1;
  logic [3:0]     WATCHDOG_TIMEOUT = 4'h1;
  logic           CORE_ACCEPT, CORE_RETURN, PUSH_PC, LOAD_PC;
  tlia_req_type   REQ;
  logic [15:0]    LOAD_VECTOR;
  logic [7:0]     ENABLE_REG, PRIORITY_REG, EXTRA_REG, takes;
  logic [1:0]     IN_SERVICE;
  logic           accept_en = 1'b0, ret_cmd = 1'b0, order_bad;
  int             errors = 0, compares = 0;
  tlia_row_type   rows [0:20];

  // 50 MHz system clock
  always #10 CLK_SYS = ~CLK_SYS;

  tlia_arbiter #(.TIMEOUT_W(4)) DUT (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .FLAGS(FLAGS),
    .ENABLE_WR_DATA(ENABLE_WR_DATA), .ENABLE_WR(ENABLE_WR), .PRIORITY_WR_DATA(PRIORITY_WR_DATA),
    .PRIORITY_WR(PRIORITY_WR), .EXTRA_WR_DATA(EXTRA_WR_DATA), .EXTRA_WR(EXTRA_WR),
    .WATCHDOG_IRQ_SELECT(WATCHDOG_IRQ_SELECT), .WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT),
    .CORE_ACCEPT(CORE_ACCEPT), .CORE_RETURN(CORE_RETURN), .REQ(REQ), .PUSH_PC(PUSH_PC),
    .LOAD_PC(LOAD_PC), .LOAD_VECTOR(LOAD_VECTOR), .ENABLE_REG(ENABLE_REG),
    .PRIORITY_REG(PRIORITY_REG), .EXTRA_REG(EXTRA_REG), .IN_SERVICE(IN_SERVICE));

  tlia_core_model core (.clk_sys(CLK_SYS), .rst_n(RST_N), .req(REQ), .push_pc(PUSH_PC),
    .load_pc(LOAD_PC), .core_accept(CORE_ACCEPT), .core_return(CORE_RETURN),
    .accept_en(accept_en), .ret_cmd(ret_cmd), .order_bad(order_bad), .takes(takes));

  // ********************************************************************
  // Helper tasks
  // ********************************************************************
  // Compare and count; four-state compare, so an unknown matches only the same unknown
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Step to just after the next rising edge, where inputs change
  task automatic tick();
    @(posedge CLK_SYS);
    #1;
  endtask : tick

  // Write all three configuration bytes in one cycle
  task automatic wr(input logic [7:0] en, input logic [7:0] pri, input logic [7:0] ext);
    {ENABLE_WR_DATA, PRIORITY_WR_DATA, EXTRA_WR_DATA} = {en, pri, ext};
    {ENABLE_WR, PRIORITY_WR, EXTRA_WR} = 3'b111;
    tick();
    {ENABLE_WR, PRIORITY_WR, EXTRA_WR} = 3'b000;
    // Strobes stay low for a cycle, so a following write never re-raises them at once
    tick();
  endtask : wr

  // Bounded wait for a request; a hang ends the run
  task automatic wait_req();
    int i;
    // Let the new flags settle for a cycle before sampling the combinational request
    tick();
    for (i = 0; i < 20 && REQ.valid !== 1'b1; i++) tick();
    if (REQ.valid !== 1'b1) begin
      errors++;
      finish_test();
    end
  endtask : wait_req

  // Core takes the request; push then load follow on fixed cycles
  task automatic take(input logic [15:0] vec, input logic [1:0] is_exp);
    accept_en = 1'b1;
    tick();
    accept_en = 1'b0;
    check({15'h0, PUSH_PC}, 16'h1);
    check({14'h0, IN_SERVICE}, {14'h0, is_exp});
    tick();
    check({15'h0, LOAD_PC}, 16'h1);
    check(LOAD_VECTOR, vec);
    tick();
  endtask : take

  // One return-from-interrupt pulse
  task automatic ret();
    ret_cmd = 1'b1;
    tick();
    ret_cmd = 1'b0;
    // Gap cycle, so two returns in a row are two separate pulses
    tick();
  endtask : ret

  // Single place where the run ends
  task automatic finish_test();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    rows = '{'{15'h1000, 8'hFF, 8'h00, 8'h07, 4'(SRC_EXT0), VEC_EXT0, 1'b0},
             '{15'h0200, 8'hFF, 8'h00, 8'h07, 4'(SRC_TIMER0), VEC_TIMER0, 1'b0},
             '{15'h0100, 8'hFF, 8'h00, 8'h07, 4'(SRC_EXT1), VEC_EXT1, 1'b0},
             '{15'h0080, 8'hFF, 8'h00, 8'h07, 4'(SRC_TIMER1), VEC_TIMER1, 1'b0},
             '{15'h0010, 8'hFF, 8'h00, 8'h07, 4'(SRC_UART), VEC_UART, 1'b0},
             '{15'h0008, 8'hFF, 8'h00, 8'h07, 4'(SRC_UART), VEC_UART, 1'b0},
             '{15'h0004, 8'hFF, 8'h00, 8'h07, 4'(SRC_TIMER2), VEC_TIMER2, 1'b0},
             '{15'h0002, 8'hFF, 8'h00, 8'h07, 4'(SRC_TIMER2), VEC_TIMER2, 1'b0},
             '{15'h0400, 8'hFF, 8'h00, 8'h07, 4'(SRC_ADC), VEC_ADC, 1'b0},
             '{15'h0040, 8'hFF, 8'h00, 8'h07, 4'(SRC_SERIF), VEC_SERIF, 1'b0},
             '{15'h0020, 8'hFF, 8'h00, 8'h07, 4'(SRC_SERIF), VEC_SERIF, 1'b0},
             '{15'h4000, 8'hFF, 8'h00, 8'h07, 4'(SRC_SUPPLY), VEC_SUPPLY, 1'b0},
             '{15'h0001, 8'hFF, 8'h00, 8'h07, 4'(SRC_INTERVAL), VEC_INTERVAL, 1'b0},
             '{15'h2000, 8'hFF, 8'h00, 8'h07, 4'(SRC_WATCHDOG), VEC_WATCHDOG, 1'b1},
             '{15'h5FFF, 8'hFF, 8'h00, 8'h07, 4'(SRC_SUPPLY), VEC_SUPPLY, 1'b0},
             '{15'h0FFF, 8'hFF, 8'h00, 8'h07, 4'(SRC_ADC), VEC_ADC, 1'b0},
             '{15'h01FF, 8'hFF, 8'h00, 8'h07, 4'(SRC_EXT1), VEC_EXT1, 1'b0},
             '{15'h003F, 8'hFF, 8'h00, 8'h07, 4'(SRC_SERIF), VEC_SERIF, 1'b0},
             '{15'h1200, 8'hFF, 8'h02, 8'h07, 4'(SRC_TIMER0), VEC_TIMER0, 1'b1},
             '{15'h3000, 8'h7F, 8'h00, 8'h07, 4'(SRC_WATCHDOG), VEC_WATCHDOG, 1'b1},
             '{15'h4001, 8'hFF, 8'h00, 8'h47, 4'(SRC_INTERVAL), VEC_INTERVAL, 1'b1}};
    // Reset held for four cycles
    repeat (4) @(posedge CLK_SYS);
    #1;
    RST_N = 1'b1;
    check({ENABLE_REG, PRIORITY_REG}, {ENABLE_RESET, PRIORITY_RESET});
    check({6'h0, IN_SERVICE, EXTRA_REG}, {8'h00, EXTRA_RESET});
    check({15'h0, REQ.valid}, 16'h0);
    tick();
    // Reserved bits read back as zero
    wr(8'hFF, 8'hFF, 8'hFF);
    check({ENABLE_REG, PRIORITY_REG}, 16'hFF7F);
    check({8'h00, EXTRA_REG}, 16'h0077);
    // Table: each row one grant, then return
    foreach (rows[i]) begin
      wr(rows[i].en, rows[i].pri, rows[i].ext);
      FLAGS = rows[i].flags;
      wait_req();
      check({12'h0, REQ.source}, {12'h0, rows[i].src});
      check({15'h0, REQ.high}, {15'h0, rows[i].high});
      check(REQ.vector, rows[i].vec);
      take(rows[i].vec, rows[i].high ? 2'b10 : 2'b01);
      FLAGS = '0;
      ret();
      check({14'h0, IN_SERVICE}, 16'h0);
    end
    // Nesting: low routine, low waits, high preempts
    wr(8'h8E, 8'h08, 8'h00);
    FLAGS = 15'h0200;
    wait_req();
    take(VEC_TIMER0, 2'b01);
    FLAGS = 15'h0300;
    repeat (3) tick();
    check({15'h0, REQ.valid}, 16'h0);
    FLAGS = 15'h0380;
    wait_req();
    check({12'h0, REQ.source}, {12'h0, 4'(SRC_TIMER1)});
    take(VEC_TIMER1, 2'b11);
    FLAGS = 15'h0100;
    ret();
    check({14'h0, IN_SERVICE}, 16'h1);
    check({15'h0, REQ.valid}, 16'h0);
    ret();
    wait_req();
    check({12'h0, REQ.source}, {12'h0, 4'(SRC_EXT1)});
    take(VEC_EXT1, 2'b01);
    FLAGS = '0;
    ret();
    // Masking by individual enable and by watchdog conditions
    wr(8'h80, 8'h00, 8'h00);
    FLAGS = 15'h1000;
    repeat (2) tick();
    check({15'h0, REQ.valid}, 16'h0);
    FLAGS = 15'h2000;
    WATCHDOG_IRQ_SELECT = 1'b0;
    tick();
    check({15'h0, REQ.valid}, 16'h0);
    WATCHDOG_IRQ_SELECT = 1'b1;
    WATCHDOG_TIMEOUT = 4'h0;
    tick();
    check({15'h0, REQ.valid}, 16'h0);
    WATCHDOG_TIMEOUT = 4'h1;
    // Global enable off: an individually enabled source is masked, the watchdog is not
    wr(8'h01, 8'h00, 8'h00);
    FLAGS = 15'h1000;
    repeat (2) tick();
    check({15'h0, REQ.valid}, 16'h0);
    FLAGS = 15'h3000;
    wait_req();
    check({12'h0, REQ.source}, {12'h0, 4'(SRC_WATCHDOG)});
    take(VEC_WATCHDOG, 2'b10);
    FLAGS = '0;
    ret();
    check({8'h00, takes}, 16'h0019);
    check({15'h0, order_bad}, 16'h0);
    // Reset in mid-run clears the enable and priority bytes
    wr(8'hFF, 8'hFF, 8'hFF);
    RST_N = 1'b0;
    tick();
    check({ENABLE_REG, PRIORITY_REG}, 16'h0000);
    finish_test();
  end
endmodule : tb_two_level_interrupt_arbiter

`default_nettype wire
